/* File: core/tsm_timer_split.sv */
// paired counter/timers with split eight-bit mode, avalon-mm slave
// assumes pins are asynchronous and prescale_tick is a clk-domain pulse
`timescale 1ns/1ps
`include "tsm_params.svh"

// Behaviour
// - first timer mode 3 splits into two bytes
// - low byte uses first run, gate, source, flag
// - low byte counts clock ticks or external events
// - high byte counts clock or prescale only
// - high byte runs only with second run bit
// - high byte overflow sets second overflow flag
// - split: second timer no external clock, flag
// - second timer overflow still feeds baud logic
// - split: second timer runs unless mode 3
// - second timer mode 3 never counts
// - mode register fields ordered gate, source, mode
module tsm_timer_split
	import tsm_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// timebase and pins
	input  wire logic              prescale_tick,
	input  wire logic              count_pin0,
	input  wire logic              gate_pin0,
	input  wire logic              count_pin1,
	input  wire logic              gate_pin1,
	// events out
	output logic                   baud_overflow,
	output logic                   irq
);

	// refuse address widths that cannot reach the map
	if (ADDR_W < `TSM_MIN_ADDR_W) begin : g_chk
		$error("tsm_timer_split: ADDR_W too small");
	end

	// registers
	tsm_mode_s   mode_r;
	logic [7:0]  ctrl_r, stat_r, mask_r;
	logic [15:0] t0_r, t1_r, t0_nxt, t1_nxt;
	logic [31:0] rdata_r;
	logic        ack_r, baud_r;

	// pin synchronisers
	logic [`TSM_NPINS-1:0] pin_raw, pin_rise;
	logic [`TSM_NPINS-1:0] pin_s1_r, pin_s2_r, pin_s3_r;

	// datapath
	logic        split, wr_en, tick0, tick1, run0;
	logic        lo_inc, hi_inc, t1_run, t1_inc;
	logic        t0_ovf, hi_wrap, t1_ovf, tf0_set, tf1_set;
	logic [9:0]  idx;
	logic [7:0]  wbyte, rd_mux;
	logic [16:0] t0_step, t1_step;

	// one count step for modes 0, 1 and 2; bit 16 flags overflow
	function automatic logic [16:0] tsm_step(input tsm_tmode_e m,
		input logic [15:0] v);
		logic [12:0] c13;
		logic [16:0] r;
		c13 = 13'h0000;
		r   = 17'h00000;
		case (m)
			TSM_M13: begin
				c13 = {v[15:8], v[4:0]} + 13'h0001;
				r = {(v[15:8] == 8'hFF && v[4:0] == 5'h1F),
					c13[12:5], v[7:5], c13[4:0]};
			end
			TSM_M16: begin
				r = {(v == 16'hFFFF), v + 16'h0001};
			end
			TSM_M8R: begin
				r = {(v[7:0] == 8'hFF), v[15:8],
					(v[7:0] == 8'hFF) ? v[15:8] : v[7:0] + 8'h01};
			end
			default: begin
				r = {1'b0, v};
			end
		endcase
		return r;
	endfunction

	// two flops per pin, third flop only for edge detection
	assign pin_raw[`TSM_PIN_CNT0]  = count_pin0;
	assign pin_raw[`TSM_PIN_FIRST_TIMER_GATE] = gate_pin0;
	assign pin_raw[`TSM_PIN_CNT1]  = count_pin1;
	assign pin_raw[`TSM_PIN_SECOND_TIMER_GATE] = gate_pin1;
	for (genvar i = 0; i < `TSM_NPINS; i++) begin : g_sync
		always_ff @(posedge clk) begin
			if (!reset_n) begin
				pin_s1_r[i] <= 1'b0;
				pin_s2_r[i] <= 1'b0;
				pin_s3_r[i] <= 1'b0;
			end else begin
				pin_s1_r[i] <= pin_raw[i];
				pin_s2_r[i] <= pin_s1_r[i];
				pin_s3_r[i] <= pin_s2_r[i];
			end
		end
		assign pin_rise[i] = pin_s2_r[i] & ~pin_s3_r[i];
	end

	// avalon decode, one wait state on every access
	assign idx         = address[11:2];
	assign wbyte       = writedata[7:0];
	assign waitrequest = (read | write) & ~ack_r;
	assign wr_en       = write & ack_r;
	assign readdata    = rdata_r;

	// timebases: every clock or the prescaled tick
	assign tick0 = ctrl_r[`TSM_CTL_FST0] | prescale_tick;
	assign tick1 = ctrl_r[`TSM_CTL_FST1] | prescale_tick;
	assign split = (mode_r.first_timer_mode == TSM_SPLIT);

	// first timer, also the low byte in split mode
	assign run0 = ctrl_r[`TSM_CTL_RUN0] &
		(~mode_r.first_timer_gate | pin_s2_r[`TSM_PIN_FIRST_TIMER_GATE]);
	assign lo_inc = run0 & (mode_r.first_timer_source_select ?
		pin_rise[`TSM_PIN_CNT0] : tick0);
	// high byte: second run bit, internal timebase only
	assign hi_inc  = split & ctrl_r[`TSM_CTL_RUN1] & tick1;
	assign hi_wrap = hi_inc & (t0_r[15:8] == 8'hFF);
	assign t0_step = tsm_step(mode_r.first_timer_mode, t0_r);
	assign t0_ovf  = split ? (lo_inc & (t0_r[7:0] == 8'hFF))
		: (lo_inc & t0_step[16]);

	// second timer: mode 3 halts it; in split mode the mode is the run
	always_comb begin
		t1_run = 1'b0;
		if (mode_r.second_timer_mode == TSM_SPLIT) begin
			t1_run = 1'b0;
		end else if (split) begin
			t1_run = 1'b1;
		end else begin
			t1_run = ctrl_r[`TSM_CTL_RUN1] & (~mode_r.second_timer_gate |
				pin_s2_r[`TSM_PIN_SECOND_TIMER_GATE]);
		end
	end
	assign t1_inc = t1_run &
		((split | ~mode_r.second_timer_source_select) ? tick1
		: pin_rise[`TSM_PIN_CNT1]);
	assign t1_step = tsm_step(mode_r.second_timer_mode, t1_r);
	assign t1_ovf  = t1_inc & t1_step[16];

	// flag sources; split mode hands the second flag to the high byte
	assign tf0_set = t0_ovf;
	assign tf1_set = split ? hi_wrap : t1_ovf;

	// first timer next value, bus write wins over a count
	always_comb begin
		t0_nxt = t0_r;
		if (split) begin
			if (lo_inc) begin
				t0_nxt[7:0] = t0_r[7:0] + 8'h01;
			end
			if (hi_inc) begin
				t0_nxt[15:8] = t0_r[15:8] + 8'h01;
			end
		end else if (lo_inc) begin
			t0_nxt = t0_step[15:0];
		end
		if (wr_en && idx == `TSM_IDX_T0LO) begin
			t0_nxt[7:0] = wbyte;
		end
		if (wr_en && idx == `TSM_IDX_T0HI) begin
			t0_nxt[15:8] = wbyte;
		end
	end

	// second timer next value
	always_comb begin
		t1_nxt = t1_r;
		if (t1_inc) begin
			t1_nxt = t1_step[15:0];
		end
		if (wr_en && idx == `TSM_IDX_T1LO) begin
			t1_nxt[7:0] = wbyte;
		end
		if (wr_en && idx == `TSM_IDX_T1HI) begin
			t1_nxt[15:8] = wbyte;
		end
	end

	// counters
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			t0_r <= `TSM_RST_CNT;
			t1_r <= `TSM_RST_CNT;
		end else begin
			t0_r <= t0_nxt;
			t1_r <= t1_nxt;
		end
	end

	// mode, control and mask registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mode_r <= `TSM_RST_MODE;
			ctrl_r <= `TSM_RST_CTRL;
			mask_r <= `TSM_RST_MASK;
		end else if (wr_en) begin
			if (idx == `TSM_IDX_MODE) begin
				mode_r <= wbyte;
			end
			if (idx == `TSM_IDX_CTRL) begin
				ctrl_r <= {4'h0, wbyte[3:0]};
			end
			if (idx == `TSM_IDX_MASK) begin
				mask_r <= {6'h00, wbyte[1:0]};
			end
		end
	end

	// sticky flags, write one to clear, a set wins over the clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stat_r <= `TSM_RST_STAT;
		end else begin
			if (wr_en && idx == `TSM_IDX_STAT) begin
				stat_r <= stat_r & ~{6'h00, wbyte[1:0]} |
					{6'h00, tf1_set, tf0_set};
			end else begin
				stat_r <= stat_r | {6'h00, tf1_set, tf0_set};
			end
		end
	end

	// baud event pulse, flops after every second timer overflow
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			baud_r <= 1'b0;
		end else begin
			baud_r <= t1_ovf;
		end
	end
	assign baud_overflow = baud_r;
	assign irq           = |(stat_r & mask_r);

	// read mux, unmapped reads give zero
	always_comb begin
		case (idx)
			`TSM_IDX_STAT: rd_mux = stat_r;
			`TSM_IDX_MASK: rd_mux = mask_r;
			`TSM_IDX_CTRL: rd_mux = ctrl_r;
			`TSM_IDX_MODE: rd_mux = mode_r;
			`TSM_IDX_T0LO: rd_mux = t0_r[7:0];
			`TSM_IDX_T0HI: rd_mux = t0_r[15:8];
			`TSM_IDX_T1LO: rd_mux = t1_r[7:0];
			`TSM_IDX_T1HI: rd_mux = t1_r[15:8];
			default:       rd_mux = 8'h00;
		endcase
	end

	// wait-state toggle and read capture
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ack_r   <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= (read | write) & ~ack_r;
			if (read && !ack_r) begin
				rdata_r <= {24'h000000, rd_mux};
			end
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic no_t0_wr, no_t1_wr;
	assign no_t0_wr = !(wr_en && (idx == `TSM_IDX_T0LO ||
		idx == `TSM_IDX_T0HI));
	assign no_t1_wr = !(wr_en && (idx == `TSM_IDX_T1LO ||
		idx == `TSM_IDX_T1HI));

	a_split_lo_wrap: assert property (split && lo_inc &&
		t0_r[7:0] == 8'hFF && no_t0_wr |=> t0_r[7:0] == 8'h00 &&
		stat_r[`TSM_ST_OVF0])
		else $error("low byte did not wrap with flag");
	a_lo_flag_set: assert property (split && tf0_set |=>
		stat_r[`TSM_ST_OVF0])
		else $error("first overflow flag not set");
	a_hi_flag_set: assert property (split && hi_inc &&
		t0_r[15:8] == 8'hFF |=> stat_r[`TSM_ST_OVF1])
		else $error("high byte overflow lost");
	a_hi_hold_stop: assert property (split &&
		!ctrl_r[`TSM_CTL_RUN1] && no_t0_wr |=> $stable(t0_r[15:8]))
		else $error("high byte moved while stopped");
	a_hi_int_src: assert property (split && !tick1 &&
		no_t0_wr |=> $stable(t0_r[15:8]))
		else $error("high byte counted a foreign source");
	a_lo_ext_src: assert property (split &&
		mode_r.first_timer_source_select &&
		!pin_rise[`TSM_PIN_CNT0] && no_t0_wr |=> $stable(t0_r[7:0]))
		else $error("low byte counted without external edge");
	a_split_indep: assert property (split && lo_inc &&
		!hi_inc && no_t0_wr |=> $stable(t0_r[15:8]))
		else $error("bytes not independent in split mode");
	a_t1_mode3_stop: assert property (
		mode_r.second_timer_mode == TSM_SPLIT && no_t1_wr |=>
		$stable(t1_r))
		else $error("second timer counted in mode 3");
	a_t1_no_flag: assert property (split && t1_ovf &&
		!hi_wrap && !stat_r[`TSM_ST_OVF1] |=> !stat_r[`TSM_ST_OVF1])
		else $error("second timer set its flag in split mode");
	a_t1_split_run: assert property (split && tick1 &&
		mode_r.second_timer_mode != TSM_SPLIT |-> t1_inc)
		else $error("second timer idle in split mode");
	a_baud_event: assert property (
		baud_overflow == $past(t1_ovf))
		else $error("baud event missing");
	a_mode_fields: assert property (wr_en &&
		idx == `TSM_IDX_MODE |=>
		mode_r.second_timer_gate == $past(wbyte[7]) &&
		mode_r.first_timer_mode == $past(wbyte[1:0]))
		else $error("mode register layout wrong");

	c_split_lo_wrap: cover property (split && tf0_set);
	c_split_hi_wrap: cover property (split && hi_wrap);
	c_baud_in_split: cover property (split && t1_ovf);
	c_irq_rise:      cover property ($rose(irq));

endmodule

/* File: dv/tsm_pin_model.sv */
// external count source on the far side of the timer count pin
// assumes clk is the timer clock; pulses stay wide for the pin sync
`timescale 1ns/1ps
module tsm_pin_model (
	// clock
	input  wire logic clk,
	// count pin
	output logic      count_pin
);
	// pin rests low between bursts
	initial count_pin = 1'b0;

	// n rising edges, three clocks high and three low
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk);
			count_pin <= 1'b1;
			repeat (3) @(posedge clk);
			count_pin <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
endmodule

/* File: dv/tsm_timer_split_test.sv */
// self-checking bench for the split eight-bit timer
// assumes tsm_pkg and the pin model are compiled before it
`timescale 1ns/1ps
`include "tsm_params.svh"
module tsm_timer_split_test;
	import tsm_pkg::*;
	logic        clk, reset_n, read, write, prescale_tick;
	logic [11:0] address;
	logic [31:0] writedata, readdata;
	logic        waitrequest, count_pin0, gate_pin0, baud_overflow, irq;
	logic [7:0]  v;
	int          failures = 0;
	int          n_tests = 0;
	int          n_baud = 0;
	int          n;

	tsm_timer_split u_tsm_timer_split (
		.clk(clk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .prescale_tick(prescale_tick),
		.count_pin0(count_pin0), .gate_pin0(gate_pin0),
		.count_pin1(count_pin0), .gate_pin1(1'b1),
		.baud_overflow(baud_overflow), .irq(irq)
	);
	tsm_pin_model u_tsm_pin_model (.clk(clk), .count_pin(count_pin0));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// counts baud pulses leaving the block
	always @(posedge clk) if (baud_overflow === 1'b1) n_baud <= n_baud + 1;

	// compare and record
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [9:0] idx,
		input logic [7:0] d);
		@(posedge clk);
		address   <= {idx, 2'b00};
		write     <= wr;
		read      <= ~wr;
		writedata <= {24'h000000, d};
		do @(posedge clk); while (waitrequest !== 1'b0);
		v = readdata[7:0];
		write <= 1'b0;
		read  <= 1'b0;
	endtask

	// n back-to-back timebase ticks
	task automatic ticks(input int k);
		@(posedge clk);
		prescale_tick <= 1'b1;
		repeat (k) @(posedge clk);
		prescale_tick <= 1'b0;
	endtask

	// reset value, readback, unmapped place
	task automatic t_regs;
		bus(0, `TSM_IDX_MODE, 8'h00);
		chk(v, `TSM_RST_MODE);
		bus(1, `TSM_IDX_MODE, 8'hA5);
		bus(0, `TSM_IDX_MODE, 8'h00);
		chk(v, 8'hA5);
		bus(1, 10'h3FF, 8'h5A);
		bus(0, 10'h3FF, 8'h00);
		chk(v, 8'h00);
	endtask

	// low byte wraps and flags, high byte holds without second run
	task automatic t_low;
		bus(1, `TSM_IDX_MODE, 8'h03);
		bus(1, `TSM_IDX_CTRL, 8'h01);
		bus(1, `TSM_IDX_T0LO, 8'hFE);
		bus(1, `TSM_IDX_T0HI, 8'h10);
		ticks(3);
		bus(0, `TSM_IDX_T0LO, 8'h00);
		chk(v, 8'h01);
		bus(0, `TSM_IDX_T0HI, 8'h00);
		chk(v, 8'h10);
		bus(0, `TSM_IDX_STAT, 8'h00);
		chk(v, 8'h01);
	endtask

	// high byte overflow raises second flag and interrupt
	task automatic t_high;
		bus(1, `TSM_IDX_STAT, 8'h03);
		bus(1, `TSM_IDX_CTRL, 8'h03);
		bus(1, `TSM_IDX_T0HI, 8'hFF);
		ticks(1);
		bus(0, `TSM_IDX_T0HI, 8'h00);
		chk(v, 8'h00);
		bus(0, `TSM_IDX_STAT, 8'h00);
		chk(v, 8'h02);
		bus(1, `TSM_IDX_MASK, 8'h02);
		@(negedge clk);
		chk({7'h00, irq}, 8'h01);
		bus(1, `TSM_IDX_STAT, 8'h02);
		@(negedge clk);
		chk({7'h00, irq}, 8'h00);
	endtask

	// low byte counts pin edges, high byte ignores them
	task automatic t_ext;
		bus(1, `TSM_IDX_MODE, 8'h07);
		bus(1, `TSM_IDX_T0LO, 8'h00);
		bus(1, `TSM_IDX_T0HI, 8'h00);
		u_tsm_pin_model.pulse(5);
		repeat (4) @(posedge clk);
		bus(0, `TSM_IDX_T0LO, 8'h00);
		chk(v, 8'h05);
		bus(0, `TSM_IDX_T0HI, 8'h00);
		chk(v, 8'h00);
	endtask

	// gate bit lets a low gate pin hold the low byte
	task automatic t_gate;
		gate_pin0 <= 1'b0;
		bus(1, `TSM_IDX_MODE, 8'h0B);
		bus(1, `TSM_IDX_T0LO, 8'h00);
		ticks(3);
		bus(0, `TSM_IDX_T0LO, 8'h00);
		chk(v, 8'h00);
		gate_pin0 <= 1'b1;
		repeat (3) @(posedge clk);
		ticks(2);
		bus(0, `TSM_IDX_T0LO, 8'h00);
		chk(v, 8'h02);
	endtask

	// second timer runs by mode only, feeds baud, never flags
	task automatic t_second;
		bus(1, `TSM_IDX_CTRL, 8'h00);
		bus(1, `TSM_IDX_STAT, 8'h03);
		bus(1, `TSM_IDX_MODE, 8'h23);
		bus(1, `TSM_IDX_T1HI, 8'hFE);
		bus(1, `TSM_IDX_T1LO, 8'hFE);
		n = n_baud;
		ticks(2);
		repeat (2) @(posedge clk);
		chk(8'(n_baud - n), 8'h01);
		bus(0, `TSM_IDX_T1LO, 8'h00);
		chk(v, 8'hFE);
		bus(0, `TSM_IDX_STAT, 8'h00);
		chk(v, 8'h00);
		bus(1, `TSM_IDX_MODE, 8'h33);
		n = n_baud;
		ticks(3);
		repeat (2) @(posedge clk);
		bus(0, `TSM_IDX_T1LO, 8'h00);
		chk(v, 8'hFE);
		chk(8'(n_baud - n), 8'h00);
		bus(1, `TSM_IDX_MODE, 8'h63);
		u_tsm_pin_model.pulse(3);
		repeat (4) @(posedge clk);
		bus(0, `TSM_IDX_T1LO, 8'h00);
		chk(v, 8'hFE);
	endtask

	// verdict and end of run
	task automatic print_verdict;
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict();
	end

	// reset then scenarios
	initial begin
		reset_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 12'h000;
		writedata = 32'h00000000;
		prescale_tick = 1'b0;
		gate_pin0 = 1'b1;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_low();
		t_high();
		t_ext();
		t_gate();
		t_second();
		print_verdict();
	end
endmodule

/* File: shared/tsm_params.svh */
// register offsets, field positions and reset values of the split timer
// assumes inclusion by bare name from the package and the core module
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH

// register indices, byte address is four times the index
`define TSM_IDX_STAT  10'h080
`define TSM_IDX_MASK  10'h081
`define TSM_IDX_CTRL  10'h088
`define TSM_IDX_MODE  10'h089
`define TSM_IDX_T0LO  10'h08A
`define TSM_IDX_T1LO  10'h08B
`define TSM_IDX_T0HI  10'h08C
`define TSM_IDX_T1HI  10'h08D

// reset values
`define TSM_RST_MODE  8'h00
`define TSM_RST_CTRL  8'h00
`define TSM_RST_STAT  8'h00
`define TSM_RST_MASK  8'h00
`define TSM_RST_CNT   16'h0000

// control register bits
`define TSM_CTL_RUN0  0
`define TSM_CTL_RUN1  1
`define TSM_CTL_FST0  2
`define TSM_CTL_FST1  3

// status and mask bits
`define TSM_ST_OVF0   0
`define TSM_ST_OVF1   1

// pin vector positions
`define TSM_PIN_CNT0  0
`define TSM_PIN_FIRST_TIMER_GATE 1
`define TSM_PIN_CNT1  2
`define TSM_PIN_SECOND_TIMER_GATE 3
`define TSM_NPINS     4

// least byte address width the decoder needs
`define TSM_MIN_ADDR_W 12

`endif

/* File: shared/tsm_pkg.sv */
// types shared by the split timer core and its bench
// assumes tsm_params.svh sits on the include path
package tsm_pkg;
	`include "tsm_params.svh"

	// timer operating modes
	typedef enum logic [1:0] {
		TSM_M13   = 2'b00,
		TSM_M16   = 2'b01,
		TSM_M8R   = 2'b10,
		TSM_SPLIT = 2'b11
	} tsm_tmode_e;

	// timer mode select register layout, msb first
	typedef struct packed {
		logic       second_timer_gate;
		logic       second_timer_source_select;
		tsm_tmode_e second_timer_mode;
		logic       first_timer_gate;
		logic       first_timer_source_select;
		tsm_tmode_e first_timer_mode;
	} tsm_mode_s;
endpackage
